// ==== tb/ulms_assertions.sv ====
// Port-level assertions for the upper and lower memory select block
`include "ulms_defs.vh"
module ulms_assertions (
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Register writes
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  // Core bus cycle
  input wire        cycleStart,
  input wire        cycleMem,
  input wire [19:0] cycleAddr,
  input wire        cycleBusy,
  input wire        cycleEnd,
  input wire        addrPhaseDriveOn,
  // Selects and strobes
  input wire        topRegionSelectN,
  input wire        bottomRegionSelectN,
  input wire        midrangePinThreeN,
  input wire        midrangePinOneN,
  input wire        midrangeDramOwn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic lowWritten_ff;
  logic nxt_lowWritten;
  logic startTaken;
  // Lower select may only wake after a completed write to its register
  assign nxt_lowWritten = lowWritten_ff | (psel & penable & pwrite & pready
                          & (paddr == `ULMS_ADDR_LOWER));
  assign startTaken = cycleStart & ~cycleBusy;
  // First lower write, cleared by reset
  always @(posedge clk)
  begin
    lowWritten_ff <= reset ? 1'b0 : nxt_lowWritten;
  end
  a_top_hit:
    assert property (startTaken && cycleMem && cycleAddr[19:16] == 4'hf
      |=> topRegionSelectN != midrangePinThreeN) else $error("Top select missing");
  a_top_low_half:
    assert property (startTaken && !cycleAddr[19] |=> topRegionSelectN && midrangePinThreeN)
      else $error("Top select below its floor");
  a_bottom_high_half:
    assert property (startTaken && cycleAddr[19] |=> bottomRegionSelectN)
      else $error("Bottom select above its ceiling");
  a_bottom_before_write:
    assert property (!lowWritten_ff |-> bottomRegionSelectN)
      else $error("Bottom select before any write");
  a_end_not_early:
    assert property (startTaken |=> cycleBusy throughout (!cycleEnd [*3]))
      else $error("Cycle ended too soon");
  a_end_bounded:
    assert property (startTaken |-> ##[4:300] cycleEnd) else $error("Cycle never ended");
  a_drive_after_start:
    assert property (addrPhaseDriveOn |-> $past(startTaken) ##1 !addrPhaseDriveOn)
      else $error("Address drive outside address phase");
  a_row_frees_select:
    assert property (!midrangePinThreeN |-> topRegionSelectN && midrangeDramOwn)
      else $error("Row strobe with top select");
  a_col_needs_row:
    assert property (!midrangePinOneN |-> !midrangePinThreeN || !bottomRegionSelectN)
      else $error("Column strobe without row strobe");
  a_end_releases:
    assert property (cycleEnd |-> topRegionSelectN && bottomRegionSelectN && midrangePinThreeN)
      else $error("Select held past cycle end");
  // Main scenarios reached
  c_top: cover property (!topRegionSelectN);
  c_bottom: cover property (!bottomRegionSelectN);
  c_row: cover property (!midrangePinThreeN);
  c_col: cover property (!midrangePinOneN);
endmodule

bind ulms_top ulms_assertions u_ulms_assertions (
  .clk, .reset, .psel, .penable, .pwrite, .pready, .paddr, .cycleStart, .cycleMem,
  .cycleAddr, .cycleBusy, .cycleEnd, .addrPhaseDriveOn, .topRegionSelectN,
  .bottomRegionSelectN, .midrangePinThreeN, .midrangePinOneN, .midrangeDramOwn
);

// ==== tb/ulms_mem_model.sv ====
// External memory that answers ready after a set number of selected cycles
module ulms_mem_model (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Selects seen from the block
  input  wire       topRegionSelectN,
  input  wire       bottomRegionSelectN,
  input  wire       midrangePinThreeN,
  // Access time and ready line
  input  wire [7:0] stallCycles,
  output logic      extReady
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Idle line is driven low while no select is active, so no stale answer
  always @(posedge clk)
  begin
    if (reset || (topRegionSelectN & bottomRegionSelectN & midrangePinThreeN))
    begin
      cnt <= 0;
      extReady <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      extReady <= (cnt >= stallCycles);
    end
  end
endmodule

// ==== tb/ulms_top_tb.sv ====
// Self-checking bench for the upper and lower memory select block
`include "ulms_defs.vh"
module ulms_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] upA = `ULMS_ADDR_UPPER;
  localparam logic [11:0] lowA = `ULMS_ADDR_LOWER;
  localparam logic [11:0] auxA = `ULMS_ADDR_AUX;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdat;
  logic [3:0]  pstrb = 4'h3;
  logic        externalInitPinN = 1, bootWidthStrap = 0, addrEnableStrap = 1, err;
  logic        cycleStart = 0, cycleMem = 1, highByteEn = 1, lowByteEn = 1;
  logic [19:0] cycleAddr = 0;
  logic [7:0]  stallCycles = 8'd15;
  logic [5:0]  seen;
  wire  [31:0] prdata;
  wire         pready, pslverr, cycleBusy, cycleEnd, addrPhaseDriveOn, topWidth16;
  wire         bottomWidth16, topRegionSelectN, bottomRegionSelectN, midrangePinThreeN;
  wire         midrangePinOneN, midrangePinTwoN, midrangeDramOwn, extReady;
  int          errors = 0, check_count = 0, len;
  logic [2:0]  lbCode [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
  logic [19:0] lbBase [4] = '{20'hf0000, 20'he0000, 20'hc0000, 20'h80000};
  logic [2:0]  ubCode [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [19:0] ubTop [4] = '{20'h0ffff, 20'h1ffff, 20'h3ffff, 20'h7ffff};

  ulms_top u_ulms_top (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .externalInitPinN, .bootWidthStrap, .addrEnableStrap, .extReady, .cycleStart,
    .cycleMem, .cycleAddr, .highByteEn, .lowByteEn, .cycleBusy, .cycleEnd, .addrPhaseDriveOn,
    .topWidth16, .bottomWidth16, .topRegionSelectN, .bottomRegionSelectN, .midrangePinThreeN,
    .midrangePinOneN, .midrangePinTwoN, .midrangeDramOwn
  );
  ulms_mem_model u_ulms_mem_model (
    .clk, .reset, .topRegionSelectN, .bottomRegionSelectN, .midrangePinThreeN, .stallCycles,
    .extReady
  );

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  // Core cycle; seen = top, bottom, row3, drive, col1, col2 ever active
  task automatic cc(input string what, input logic [19:0] a, input int w, input logic [5:0] s);
    @(posedge clk);
    cycleStart <= 1'b1;
    cycleAddr <= a;
    @(posedge clk);
    cycleStart <= 1'b0;
    len = 0;
    seen = '0;
    do
    begin
      @(negedge clk);
      len++;
      seen |= {~topRegionSelectN, ~bottomRegionSelectN, ~midrangePinThreeN,
               addrPhaseDriveOn, ~midrangePinOneN, ~midrangePinTwoN};
    end
    while (cycleEnd !== 1'b1);
    chk({what, " pins"}, s, seen);
    if (w >= 0)
      chk({what, " length"}, 5 + w, len);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    rd("upper cfg", upA, 32'hf03b);
    rd("lower cfg", lowA, 32'h0);
    rd("aux cfg", auxA, 32'ha);
    chk("top width", 1, topWidth16);
    apb(1'b0, 12'h284, 32'h0);
    chk("unmapped err", 1, err);
    cc("boot fetch", 20'hf0000, -1, 6'h24);
    chk("ready stall", 1, len > 15 && len < 30);
    cc("below boot", 20'hefff0, 0, 6'h04);
    cc("low off", 20'h12345, 0, 6'h04);
    $display("Test reset state done");
    // Ready ignored, waits follow the loop index
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, upA, {16'h0, 1'b1, lbCode[i], 12'h03c} | i);
      rd("upper rb", upA, {16'h0, 1'b1, lbCode[i], 12'h03c} | i);
      cc("upper hit", lbBase[i], i, 6'h24);
      cc("upper miss", lbBase[i] - 1, 0, 6'h04);
    end
    apb(1'b1, upA, 32'hf03c);
    $display("Test upper bounds done");
    apb(1'b1, auxA, 32'h3);
    @(negedge clk);
    chk("bottom width", 1, bottomWidth16);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, lowA, {16'h0, 1'b0, ubCode[i], 12'hf3c} | i);
      cc("lower hit", ubTop[i], i, 6'h14);
      cc("lower miss", ubTop[i] + 1, 0, 6'h04);
    end
    rd("aux on", auxA, 32'hf);
    $display("Test lower bounds done");
    apb(1'b1, upA, 32'hf0bc);
    apb(1'b1, lowA, 32'h7fbc);
    cc("upper off", 20'hf0000, 0, 6'h20);
    cc("lower off", 20'h00000, 0, 6'h10);
    cc("no hit", 20'h80000, 0, 6'h04);
    // A non-memory cycle never decodes, even inside the upper range
    @(posedge clk);
    cycleMem <= 1'b0;
    cc("io cycle", 20'hf0000, 0, 6'h04);
    @(posedge clk);
    cycleMem <= 1'b1;
    $display("Test address disable done");
    apb(1'b1, upA, 32'hf0fc);
    cc("upper dram", 20'hf0000, 0, 6'h0b);
    apb(1'b1, lowA, 32'h7f7c);
    cc("lower dram", 20'h00000, 0, 6'h17);
    chk("dram own", 1, midrangeDramOwn);
    // High byte only: the low column strobe must stay idle
    @(posedge clk);
    lowByteEn <= 1'b0;
    cc("high byte dram", 20'h00002, 0, 6'h16);
    @(posedge clk);
    lowByteEn <= 1'b1;
    $display("Test dram mode done");
    apb(1'b1, upA, 32'hf0bc);
    addrEnableStrap <= 1'b0;
    bootWidthStrap <= 1'b1;
    externalInitPinN <= 1'b0;
    repeat (8) @(posedge clk);
    externalInitPinN <= 1'b1;
    repeat (12) @(posedge clk);
    rd("aux strap", auxA, 32'h5);
    chk("top width", 0, topWidth16);
    cc("forced drive", 20'hf0000, 0, 6'h24);
    $display("Test strap reload done");
    conclude();
  end

  // Watchdog against a hung handshake
  initial
  begin
    #100us;
    errors++;
    conclude();
  end
endmodule

// ==== verilog/ulms_apb_regs.v ====
// APB slave holding the two select registers and the auxiliary register
`include "ulms_defs.vh"
module ulms_apb_regs (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Strap load at end of external init
  input  wire        strapLoad,
  input  wire        topWidthStrapVal,
  // Read-only status
  input  wire        addrEnableStrapVal,
  // Register contents
  output wire [15:0] upperCfg,
  output wire [15:0] lowerCfg,
  output wire [15:0] auxCfg,
  output wire        lowerEnabled
);

  reg  [15:0] upper_ff;
  reg  [15:0] lower_ff;
  reg  [15:0] aux_ff;
  reg         lowerOn_ff;
  wire        access;
  wire        hitUpper;
  wire        hitLower;
  wire        hitAux;
  wire        wrOk;

  // Lane merge of a 16-bit register with APB byte strobes
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0]  strb;
    begin
      lane_merge = {strb[1] ? wdat[15:8] : old[15:8], strb[0] ? wdat[7:0] : old[7:0]};
    end
  endfunction

  assign access   = psel & penable;
  assign hitUpper = (paddr == `ULMS_ADDR_UPPER);
  assign hitLower = (paddr == `ULMS_ADDR_LOWER);
  assign hitAux   = (paddr == `ULMS_ADDR_AUX);
  assign wrOk     = access & pwrite;
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready   = 1'b1;
  assign pslverr  = access & ~(hitUpper | hitLower | hitAux);

  // Register writes; reserved bits of the two select registers keep what software wrote
  always @(posedge clk)
  begin
    if (reset)
    begin
      upper_ff   <= `ULMS_UPPER_RST;           // see R2, R13
      lower_ff   <= `ULMS_LOWER_RST;
      aux_ff     <= `ULMS_AUX_RST;
      lowerOn_ff <= 1'b0;                      // see R14
    end
    else
    begin
      if (wrOk & hitUpper)
        upper_ff <= lane_merge(upper_ff, pwdata[15:0], pstrb[1:0]);  // see R23
      if (wrOk & hitLower)
      begin
        lower_ff   <= lane_merge(lower_ff, pwdata[15:0], pstrb[1:0]);
        lowerOn_ff <= 1'b1;                    // see R14
      end
      // Strap load wins over a write in the same cycle
      if (strapLoad)
        aux_ff[`ULMS_AUX_TOP_WIDTH] <= ~topWidthStrapVal;  // see R3
      else if (wrOk & hitAux & pstrb[0])
        aux_ff[`ULMS_AUX_TOP_WIDTH] <= pwdata[`ULMS_AUX_TOP_WIDTH];
      if (wrOk & hitAux & pstrb[0])
        aux_ff[`ULMS_AUX_BOT_WIDTH] <= pwdata[`ULMS_AUX_BOT_WIDTH];
    end
  end

  // Read mux, no side effects
  always @*
  begin
    prdata = 32'h00000000;
    if (hitUpper)
      prdata = {16'h0000, upper_ff};
    else if (hitLower)
      prdata = {16'h0000, lower_ff};
    else if (hitAux)
      prdata = {28'h0000000, addrEnableStrapVal, lowerOn_ff,
                aux_ff[`ULMS_AUX_TOP_WIDTH], aux_ff[`ULMS_AUX_BOT_WIDTH]};
  end

  assign upperCfg     = upper_ff;
  assign lowerCfg     = lower_ff;
  assign auxCfg       = aux_ff;
  assign lowerEnabled = lowerOn_ff;

endmodule

// ==== verilog/ulms_defs.vh ====
// Register map, field positions, reset values and bus cycle phase states
`ifndef ULMS_DEFS_VH
`define ULMS_DEFS_VH

// Register indices as printed; byte address is four times the index
`define ULMS_IDX_UPPER      10'h0a0
`define ULMS_IDX_LOWER      10'h0a2
`define ULMS_IDX_AUX        10'h0b0
`define ULMS_ADDR_UPPER     12'h280
`define ULMS_ADDR_LOWER     12'h288
`define ULMS_ADDR_AUX       12'h2c0

// Reset values
`define ULMS_UPPER_RST      16'hf03b
`define ULMS_LOWER_RST      16'h0000
`define ULMS_AUX_RST        16'h0000

// Fields shared by both select registers
`define ULMS_BOUND_HI       14
`define ULMS_BOUND_LO       12
`define ULMS_ADDR_OFF_BIT   7
`define ULMS_DRAM_ON_BIT    6
`define ULMS_RDY_IGN_BIT    2
`define ULMS_WAIT_HI        1
`define ULMS_WAIT_LO        0

// Auxiliary register fields
`define ULMS_AUX_BOT_WIDTH  0
`define ULMS_AUX_TOP_WIDTH  1
`define ULMS_AUX_LOW_ON     2
`define ULMS_AUX_ADEN       3

// Bus cycle phase states
`define ULMS_ST_IDLE        3'h0
`define ULMS_ST_ADDR        3'h1
`define ULMS_ST_DATA        3'h2
`define ULMS_ST_WAIT        3'h3
`define ULMS_ST_LAST        3'h4

`endif

// ==== verilog/ulms_sync3.v ====
// Three-stage synchroniser; output moves once stages two and three agree
module ulms_sync3 #(
  parameter       WIDTH = 1,
  parameter [0:0] INIT  = 1'b0
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset,
  // Asynchronous input and its settled copy
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;
  reg [WIDTH-1:0] stage3_ff;
  reg [WIDTH-1:0] settled_ff;
  genvar          i;

  // Stage one feeds only stage two
  always @(posedge clk)
  begin
    if (reset)
    begin
      stage1_ff <= {WIDTH{INIT}};
      stage2_ff <= {WIDTH{INIT}};
      stage3_ff <= {WIDTH{INIT}};
    end
    else
    begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // Each bit settles on its own agreement
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gBit
      always @(posedge clk)
      begin
        if (reset)
          settled_ff[i] <= INIT;
        else if (stage2_ff[i] == stage3_ff[i])
          settled_ff[i] <= stage3_ff[i];
      end
    end
  endgenerate

  assign syncOut = settled_ff;

endmodule

// ==== verilog/ulms_top.v ====
// Upper and lower memory select decode and bus cycle shaping
//
// Decided for this implementation: the APB register port.
`include "ulms_defs.vh"

// Function
// R1: Upper select live at reset, 64K, ready, 3 waits
// R2: Upper config register resets to F03Bh
// R3: Top width bit loads inverted boot strap
// R4: Upper region ends at FFFFFh; bound programmable
// R5: Decode upper bound field 111/110/100/000
// R6: Upper address-off bit suppresses address phase
// R7: Address-enable strap low forces address drive
// R8: Upper DRAM mode remaps midrange pins, select high
// R9: Address-off also applies to DRAM accesses
// R10: Ready-ignore bit chooses external ready use
// R11: Software sets ready-ignore before DRAM mode
// R12: Insert zero to three wait states
// R13: Upper wait field resets to three
// R14: Lower select off until first register write
// R15: Decode lower bound field from zero upward
// R16: Lower address-off bit suppresses address phase
// R17: Lower DRAM mode makes select a row strobe
// R18: Software clears midrange pin I/O modes first
// R19: Software programs lower width before enabling
// R20: Software writes reserved bits as documented
// R21: Selects assert with non-multiplexed address
// R22: Programmed waits finish before ready counts
// R23: Reads return written contents without side effects
module ulms_top (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // APB register port
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Pins sampled from outside
  input  wire        externalInitPinN,
  input  wire        bootWidthStrap,
  input  wire        addrEnableStrap,
  input  wire        extReady,
  // Bus cycle request from the core
  input  wire        cycleStart,
  input  wire        cycleMem,
  input  wire [19:0] cycleAddr,
  input  wire        highByteEn,
  input  wire        lowByteEn,
  // Bus cycle progress to the core
  output wire        cycleBusy,
  output wire        cycleEnd,
  output wire        addrPhaseDriveOn,
  output wire        topWidth16,
  output wire        bottomWidth16,
  // Memory select and strobe pins, active low; midrange ownership flag active high
  output wire        topRegionSelectN,
  output wire        bottomRegionSelectN,
  output wire        midrangePinThreeN,
  output wire        midrangePinOneN,
  output wire        midrangePinTwoN,
  output wire        midrangeDramOwn
);

  wire [15:0] upperCfg;
  wire [15:0] lowerCfg;
  wire [15:0] auxCfg;
  wire        lowerEnabled;
  wire        readySync;
  wire        initPinSync;
  wire        bootStrapSync;
  wire        adenStrapSync;
  reg         initPinPrev_ff;
  reg         adenStrap_ff;
  wire        strapLoad;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [1:0]  waitCnt_ff;
  reg  [1:0]  nxt_waitCnt;
  reg         hitTop_ff;
  reg         hitBot_ff;
  reg         topSelN_ff;
  reg         botSelN_ff;
  reg         row3N_ff;
  reg         colHiN_ff;
  reg         colLoN_ff;
  reg         addrDrive_ff;
  reg         endPulse_ff;
  reg         dramOwn_ff;

  wire        topHitNow;
  wire        botHitNow;
  wire        topDram;
  wire        botDram;
  wire        topAddrOff;
  wire        botAddrOff;
  wire        curReadyIgn;
  wire [1:0]  curWaits;
  wire        readyOk;
  wire        dramCycle;
  wire        suppressAddr;

  // Register file over APB
  ulms_apb_regs uRegs (
    .clk                (clk),
    .reset              (reset),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .strapLoad          (strapLoad),
    .topWidthStrapVal   (bootStrapSync),
    .addrEnableStrapVal (adenStrap_ff),
    .upperCfg           (upperCfg),
    .lowerCfg           (lowerCfg),
    .auxCfg             (auxCfg),
    .lowerEnabled       (lowerEnabled)
  );

  // Pins cross in through four flops each, three stages and a settle flop
  ulms_sync3 #(
    .WIDTH (1),
    .INIT  (1'b0)
  ) uSyncReady (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (extReady),
    .syncOut (readySync)
  );

  // Init pin and straps share one synchroniser; each bit settles on its own agreement
  ulms_sync3 #(
    .WIDTH (3),
    .INIT  (1'b0)
  ) uSyncStraps (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({externalInitPinN, bootWidthStrap, addrEnableStrap}),
    .syncOut ({initPinSync, bootStrapSync, adenStrapSync})
  );

  // Rising edge of the init pin marks the end of external reset
  // The edge flop starts low, so a pin already high at system reset
  // release still gives one load and the straps are never left unread
  assign strapLoad = initPinSync & ~initPinPrev_ff;   // see R3

  // Address-enable strap caught at release; pulled up so default high
  always @(posedge clk)
  begin
    if (reset)
    begin
      initPinPrev_ff <= 1'b0;
      adenStrap_ff   <= 1'b1;
    end
    else
    begin
      initPinPrev_ff <= initPinSync;
      if (strapLoad)
        adenStrap_ff <= adenStrapSync;   // see R7
    end
  end

  // Upper region: bit 19 set and the masked bits match the bound field
  function top_hit;
    input [19:0] addr;
    input [2:0]  bound;
    begin
      top_hit = addr[19] & ((addr[18:16] & bound) == bound);   // see R4
    end
  endfunction

  // Lower region: bit 19 clear and no address bit above the field set
  function bot_hit;
    input [19:0] addr;
    input [2:0]  bound;
    begin
      bot_hit = ~addr[19] & ((addr[18:16] & ~bound) == 3'h0);
    end
  endfunction

  // Upper is always live; the lower only once written
  assign topHitNow = cycleMem &
                     top_hit(cycleAddr, upperCfg[`ULMS_BOUND_HI:`ULMS_BOUND_LO]);  // see R1, R5
  assign botHitNow = cycleMem & lowerEnabled &
                     bot_hit(cycleAddr, lowerCfg[`ULMS_BOUND_HI:`ULMS_BOUND_LO]);  // see R14, R15

  assign topDram    = upperCfg[`ULMS_DRAM_ON_BIT];
  assign botDram    = lowerCfg[`ULMS_DRAM_ON_BIT];
  assign topAddrOff = upperCfg[`ULMS_ADDR_OFF_BIT];
  assign botAddrOff = lowerCfg[`ULMS_ADDR_OFF_BIT];

  // Suppression uses the address bit whether or not DRAM mode is on
  assign suppressAddr = adenStrap_ff &
                        ((topHitNow & topAddrOff) | (botHitNow & botAddrOff));  // see R6, R9, R16

  // Settings of the latched region; cycles that hit neither run bare
  assign curReadyIgn = hitTop_ff ? upperCfg[`ULMS_RDY_IGN_BIT] :
                       hitBot_ff ? lowerCfg[`ULMS_RDY_IGN_BIT] : 1'b1;
  assign curWaits    = hitTop_ff ? upperCfg[`ULMS_WAIT_HI:`ULMS_WAIT_LO] :
                       hitBot_ff ? lowerCfg[`ULMS_WAIT_HI:`ULMS_WAIT_LO] : 2'h0;
  // DRAM assumes ready ignored; software arranges that beforehand
  assign readyOk     = curReadyIgn | readySync;   // see R10, R11
  assign dramCycle   = (hitTop_ff & topDram) | (hitBot_ff & botDram);

  // Cycle phase sequencer
  always @*
  begin
    nxt_state   = state_ff;
    nxt_waitCnt = waitCnt_ff;
    case (state_ff)
      `ULMS_ST_IDLE:
      begin
        if (cycleStart)
          nxt_state = `ULMS_ST_ADDR;
      end
      `ULMS_ST_ADDR:
        nxt_state = `ULMS_ST_DATA;
      `ULMS_ST_DATA:
      begin
        nxt_state   = `ULMS_ST_WAIT;
        nxt_waitCnt = curWaits;   // see R12
      end
      `ULMS_ST_WAIT:
      begin
        // Waits run out first, only then may ready end or stretch
        if (waitCnt_ff != 2'h0)
          nxt_waitCnt = waitCnt_ff - 2'h1;   // see R22
        else if (readyOk)
          nxt_state = `ULMS_ST_LAST;
      end
      `ULMS_ST_LAST:
        nxt_state = `ULMS_ST_IDLE;
      default:
        nxt_state = `ULMS_ST_IDLE;
    endcase
  end

  // Phase state, wait counter and latched region hits
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_ff   <= `ULMS_ST_IDLE;
      waitCnt_ff <= 2'h0;
      hitTop_ff  <= 1'b0;
      hitBot_ff  <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      waitCnt_ff <= nxt_waitCnt;
      if ((state_ff == `ULMS_ST_IDLE) & cycleStart)
      begin
        hitTop_ff <= topHitNow;
        hitBot_ff <= botHitNow;
      end
    end
  end

  // Selects fall with the non-multiplexed address at cycle start
  always @(posedge clk)
  begin
    if (reset)
    begin
      topSelN_ff   <= 1'b1;
      botSelN_ff   <= 1'b1;
      row3N_ff     <= 1'b1;
      addrDrive_ff <= 1'b0;
      endPulse_ff  <= 1'b0;
    end
    else if ((state_ff == `ULMS_ST_IDLE) & cycleStart)
    begin
      // Upper pin stays high in DRAM mode; lower pin doubles as row strobe
      topSelN_ff   <= ~(topHitNow & ~topDram);   // see R21, R8
      row3N_ff     <= ~(topHitNow & topDram);    // see R8
      botSelN_ff   <= ~botHitNow;                // see R21, R17
      addrDrive_ff <= ~suppressAddr;             // see R7
      endPulse_ff  <= 1'b0;
    end
    else
    begin
      addrDrive_ff <= 1'b0;
      endPulse_ff  <= (state_ff == `ULMS_ST_LAST);
      if (state_ff == `ULMS_ST_LAST)
      begin
        topSelN_ff <= 1'b1;
        botSelN_ff <= 1'b1;
        row3N_ff   <= 1'b1;
      end
    end
  end

  // Column strobes follow the data phase with the byte enables
  always @(posedge clk)
  begin
    if (reset)
    begin
      colHiN_ff <= 1'b1;
      colLoN_ff <= 1'b1;
    end
    else if ((state_ff == `ULMS_ST_DATA) & dramCycle)
    begin
      colHiN_ff <= ~highByteEn;   // see R8, R17
      colLoN_ff <= ~lowByteEn;
    end
    else if ((state_ff == `ULMS_ST_LAST) | (state_ff == `ULMS_ST_IDLE))
    begin
      colHiN_ff <= 1'b1;
      colLoN_ff <= 1'b1;
    end
  end

  // Midrange pins 3..1 belong to the DRAM strobes while either bank is on;
  // registered so the pad mux switches cleanly, one cycle after the write
  always @(posedge clk)
  begin
    if (reset)
      dramOwn_ff <= 1'b0;
    else
      dramOwn_ff <= topDram | botDram;   // see R8, R17
  end

  assign midrangeDramOwn   = dramOwn_ff;
  assign midrangePinThreeN = row3N_ff;
  assign midrangePinOneN   = colHiN_ff;
  assign midrangePinTwoN   = colLoN_ff;

  // Outputs to the core and pins
  assign topRegionSelectN    = topSelN_ff;
  assign bottomRegionSelectN = botSelN_ff;
  assign addrPhaseDriveOn    = addrDrive_ff;
  assign cycleEnd            = endPulse_ff;
  assign cycleBusy           = (state_ff != `ULMS_ST_IDLE);
  assign topWidth16          = auxCfg[`ULMS_AUX_TOP_WIDTH];   // see R3
  assign bottomWidth16       = auxCfg[`ULMS_AUX_BOT_WIDTH];

endmodule
